// ---- hmc_top.sv ----
`timescale 1ns/10ps
// multiplier control: register aliases, control word and held writes
// How it works
// - both names of each operand-one register reach one store, word or byte
// - short-product low and high names alias result words zero and one
// - control bits fifteen to ten and bit one always read zero
// - delay length selects waiting for all four or low two result words
// - with held writes on, every register write waits for the selected result
// - delay length and held write enable reset to zero
// - operand-two width bit picks sixteen or thirty-two bit operand two
// - operand-one width bit picks sixteen or thirty-two bit operand one
// - bits five to four pick unsigned, signed, accumulate or signed accumulate
// - bit three enables saturation, reset zero
// - bit two enables fractional results, reset zero
// - bit zero holds result carry, the extra top bit of the result
// - in saturation or fractional mode, results leave the carry untouched
// - software may write the carry and accumulation then uses it
// - control word at index 2Ch, word and byte access, high byte resets zero
module hmc_top (
   input  wire logic                    MCLK,
   input  wire logic                    RST_N,
   input  wire logic [hmc_pkg::AW-1:0]  AWADDR,
   input  wire logic                    AWVALID,
   output logic                         AWREADY,
   input  wire logic [hmc_pkg::DW-1:0]  WDATA,
   input  wire logic [3:0]              WSTRB,
   input  wire logic                    WVALID,
   output logic                         WREADY,
   output logic      [1:0]              BRESP,
   output logic                         BVALID,
   input  wire logic                    BREADY,
   input  wire logic [hmc_pkg::AW-1:0]  ARADDR,
   input  wire logic                    ARVALID,
   output logic                         ARREADY,
   output logic      [hmc_pkg::DW-1:0]  RDATA,
   output logic      [1:0]              RRESP,
   output logic                         RVALID,
   input  wire logic                    RREADY
);
   import hmc_pkg::*;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0]  be);
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   hmc_wst_t    st_r;
   hmc_wst_t    st_nxt;
   logic        aw_have_r;
   logic        w_have_r;
   logic [7:0]  awaddr_r;
   logic [15:0] wdata_r;
   logic [1:0]  wstrb_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [15:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [15:0] ctl_r;
   logic [15:0] ctl_nxt;
   logic [31:0] op1_r;
   logic [31:0] op1_nxt;
   logic [31:0] op2_r;
   logic [31:0] op2_nxt;
   logic [63:0] res_r;
   logic [63:0] res_nxt;
   logic [63:0] u_res;
   logic        u_carry;
   logic        u_lo_load;
   logic        u_hi_load;
   logic        u_lo_ready;
   logic        u_hi_ready;

   // write address decode; both names of each register land on one store
   wire w_op1_u  = (awaddr_r == ADR_UPROD) | (awaddr_r == ADR_UPROD_L);
   wire w_op1_s  = (awaddr_r == ADR_SPROD) | (awaddr_r == ADR_SPROD_L);
   wire w_op1_ua = (awaddr_r == ADR_UACC) | (awaddr_r == ADR_UACC_L);
   wire w_op1_sa = (awaddr_r == ADR_SACC) | (awaddr_r == ADR_SACC_L);
   wire w_op1_lo = w_op1_u | w_op1_s | w_op1_ua | w_op1_sa;
   wire w_op1_hi = (awaddr_r == ADR_UPROD_H) | (awaddr_r == ADR_SPROD_H)
                 | (awaddr_r == ADR_UACC_H) | (awaddr_r == ADR_SACC_H);
   wire w_op2_16 = (awaddr_r == ADR_OP2);
   wire w_op2_lo = (awaddr_r == ADR_OP2L);
   wire w_op2_hi = (awaddr_r == ADR_OP2H);
   wire w_rw0    = (awaddr_r == ADR_RW0) | (awaddr_r == ADR_SPLO);
   wire w_rw1    = (awaddr_r == ADR_RW1) | (awaddr_r == ADR_SPHI);
   wire w_rw2    = (awaddr_r == ADR_RW2);
   wire w_rw3    = (awaddr_r == ADR_RW3);
   wire w_ctl    = (awaddr_r == ADR_CTL0);
   wire w_map    = w_op1_lo | w_op1_hi | w_op2_16 | w_op2_lo | w_op2_hi
                 | w_rw0 | w_rw1 | w_rw2 | w_rw3 | w_ctl;

   wire hwen     = ctl_r[B_HWEN];
   wire dly32    = ctl_r[B_DLY32];
   wire op1w     = ctl_r[B_OP1W];
   wire op2w     = ctl_r[B_OP2W];
   wire sel_rdy  = dly32 ? u_lo_ready : u_hi_ready;
   // hold rather than refuse, so the master never has to retry
   wire gate     = w_map & hwen & ~sel_rdy;
   wire in_wait  = (st_r == WS_WAIT);
   wire apply    = in_wait & ~gate & w_map;
   wire aw_take  = AWVALID & AWREADY;
   wire w_take   = WVALID & WREADY;
   wire ar_take  = ARVALID & ARREADY;
   wire aw_got   = aw_have_r | aw_take;
   wire w_got    = w_have_r | w_take;
   wire b_done   = (st_r == WS_RESP) & BREADY;

   // operation code implied by the operand-one name used
   wire [1:0] op_code = w_op1_s ? OP_SMUL : w_op1_ua ? OP_UACC
                      : w_op1_sa ? OP_SACC : OP_UMUL;
   wire       op_sg   = w_op1_s | w_op1_sa;
   // a low-byte write to operand one's low word is an 8-bit operand, widened by signedness
   wire [15:0] op1_lo_w = (wstrb_r == 2'h1) ? {{8{op_sg & wdata_r[7]}}, wdata_r[7:0]}
                                            : merge16(op1_r[15:0], wdata_r, wstrb_r);
   wire start = apply & (w_op2_16 | (w_op2_lo & ~op2w) | (w_op2_hi & op2w));

   // read decode, same aliasing as the write side
   wire r_op1_lo = (ARADDR == ADR_UPROD) | (ARADDR == ADR_UPROD_L) | (ARADDR == ADR_SPROD)
                 | (ARADDR == ADR_SPROD_L) | (ARADDR == ADR_UACC) | (ARADDR == ADR_UACC_L)
                 | (ARADDR == ADR_SACC) | (ARADDR == ADR_SACC_L);
   wire r_op1_hi = (ARADDR == ADR_UPROD_H) | (ARADDR == ADR_SPROD_H)
                 | (ARADDR == ADR_UACC_H) | (ARADDR == ADR_SACC_H);
   wire r_op2_lo = (ARADDR == ADR_OP2) | (ARADDR == ADR_OP2L);
   wire r_op2_hi = (ARADDR == ADR_OP2H);
   wire r_rw0    = (ARADDR == ADR_RW0) | (ARADDR == ADR_SPLO);
   wire r_rw1    = (ARADDR == ADR_RW1) | (ARADDR == ADR_SPHI);
   wire r_rw2    = (ARADDR == ADR_RW2);
   wire r_rw3    = (ARADDR == ADR_RW3);
   wire r_ctl    = (ARADDR == ADR_CTL0);
   wire r_hit    = r_op1_lo | r_op1_hi | r_op2_lo | r_op2_hi | r_rw0 | r_rw1
                 | r_rw2 | r_rw3 | r_ctl;
   wire [15:0] rd_word = r_op1_lo ? op1_r[15:0] : r_op1_hi ? op1_r[31:16]
                       : r_op2_lo ? op2_r[15:0] : r_op2_hi ? op2_r[31:16]
                       : r_rw0 ? res_r[15:0] : r_rw1 ? res_r[31:16]
                       : r_rw2 ? res_r[47:32] : r_rw3 ? res_r[63:48]
                       : r_ctl ? (ctl_r & CTL_WMASK) : 16'h0000;

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         WS_IDLE: if (aw_got && w_got) begin
            st_nxt = WS_WAIT;
         end
         WS_WAIT: if (!gate) begin
            st_nxt = WS_RESP;
         end
         WS_RESP: if (BREADY) begin
            st_nxt = WS_IDLE;
         end
         default: st_nxt = WS_IDLE;
      endcase
   end

   always_comb begin
      ctl_nxt = ctl_r;
      if (apply && w_ctl) begin
         // reserved bits never store, so they always read back zero
         ctl_nxt = merge16(ctl_r, wdata_r, wstrb_r) & CTL_WMASK;
      end
      if (apply && w_op1_lo) begin
         ctl_nxt[B_OPHI:B_OPLO] = op_code;
      end
      // carry follows the engine only in plain modes; saturation and fractional results leave it
      if (u_hi_load && !ctl_r[B_SAT] && !ctl_r[B_FRAC]) begin
         ctl_nxt[B_CARRY] = u_carry;
      end
   end

   always_comb begin
      op1_nxt = op1_r;
      op2_nxt = op2_r;
      if (apply && w_op1_lo) begin
         op1_nxt[15:0] = op1_lo_w;
      end
      if (apply && w_op1_hi) begin
         op1_nxt[31:16] = merge16(op1_r[31:16], wdata_r, wstrb_r);
      end
      if (apply && (w_op2_16 || w_op2_lo)) begin
         op2_nxt[15:0] = merge16(op2_r[15:0], wdata_r, wstrb_r);
      end
      if (apply && w_op2_hi) begin
         op2_nxt[31:16] = merge16(op2_r[31:16], wdata_r, wstrb_r);
      end
   end

   always_comb begin
      res_nxt = res_r;
      if (apply && w_rw0) begin
         res_nxt[15:0] = merge16(res_r[15:0], wdata_r, wstrb_r);
      end
      if (apply && w_rw1) begin
         res_nxt[31:16] = merge16(res_r[31:16], wdata_r, wstrb_r);
      end
      if (apply && w_rw2) begin
         res_nxt[47:32] = merge16(res_r[47:32], wdata_r, wstrb_r);
      end
      if (apply && w_rw3) begin
         res_nxt[63:48] = merge16(res_r[63:48], wdata_r, wstrb_r);
      end
      // engine results win over a software write in the same cycle
      if (u_lo_load) begin
         res_nxt[31:0] = u_res[31:0];
      end
      if (u_hi_load) begin
         res_nxt[63:32] = u_res[63:32];
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r  <= WS_IDLE;
         ctl_r <= CTL_RST;
         op1_r <= 32'h0;
         op2_r <= 32'h0;
         res_r <= 64'h0;
      end else begin
         st_r  <= st_nxt;
         ctl_r <= ctl_nxt;
         op1_r <= op1_nxt;
         op2_r <= op2_nxt;
         res_r <= res_nxt;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 16'h0000;
         wstrb_r   <= 2'h0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= AWADDR;
         end else if (b_done) begin
            aw_have_r <= 1'b0;
         end
         if (w_take) begin
            w_have_r <= 1'b1;
            wdata_r  <= WDATA[15:0];
            wstrb_r  <= WSTRB[1:0];
         end else if (b_done) begin
            w_have_r <= 1'b0;
         end
         if (in_wait && !gate) begin
            bresp_r <= w_map ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 16'h0000;
         rresp_r  <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   assign AWREADY = (st_r == WS_IDLE) & ~aw_have_r;
   assign WREADY  = (st_r == WS_IDLE) & ~w_have_r;
   assign BVALID  = (st_r == WS_RESP);
   assign BRESP   = bresp_r;
   assign ARREADY = ~rvalid_r;
   assign RVALID  = rvalid_r;
   assign RDATA   = {16'h0000, rdata_r};
   assign RRESP   = rresp_r;

   hmc_mul_unit u_mul (
      .clk      (MCLK),
      .rst_n    (RST_N),
      .start    (start),
      .op1      (op1_r),
      .op2      (op2_nxt),
      .op1_wide (op1w),
      .op2_wide (op2w),
      .op       (hmc_op_t'(ctl_r[B_OPHI:B_OPLO])),
      .sat      (ctl_r[B_SAT]),
      .frac     (ctl_r[B_FRAC]),
      .acc_in   (res_r),
      .carry_in (ctl_r[B_CARRY]),
      .res      (u_res),
      .carry    (u_carry),
      .lo_load  (u_lo_load),
      .hi_load  (u_hi_load),
      .lo_ready (u_lo_ready),
      .hi_ready (u_hi_ready)
   );

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   sequence s_held;
      in_wait && gate;
   endsequence
   sequence s_release;
      in_wait && !gate;
   endsequence

   a_held_no_resp: assert property (s_held |=> !BVALID)
      else $error("response given while write held");
   a_release_resp: assert property (s_release |=> BVALID)
      else $error("released write not answered");
   a_short_wait: assert property (in_wait && w_map && hwen && dly32 && u_lo_ready
      |=> BVALID) else $error("short result wait too long");
   a_long_wait: assert property (in_wait && w_map && hwen && !dly32 && !u_hi_ready
      |=> !BVALID) else $error("long result wait cut short");
   a_ctl_reset: assert property (disable iff (1'b0) !RST_N |-> ctl_r == CTL_RST)
      else $error("control word not cleared by reset");
   a_rsvd_read: assert property (ar_take && ARADDR == ADR_CTL0
      |=> RDATA[15:10] == 6'h00 && RDATA[1] == 1'b0) else $error("reserved bits read set");
   a_short_alias: assert property (ar_take && ARADDR == ADR_SPLO && !u_lo_load
      |=> RDATA[15:0] == $past(res_r[15:0])) else $error("short low name not aliased");
   a_op1_alias: assert property (apply && (awaddr_r == ADR_UPROD_L) && wstrb_r == 2'h3
      |=> op1_r[15:0] == $past(wdata_r) && ctl_r[B_OPHI:B_OPLO] == OP_UMUL)
      else $error("operand one alias missed");
   a_op_select: assert property (apply && w_op1_sa
      |=> ctl_r[B_OPHI:B_OPLO] == OP_SACC) else $error("operation select not set");
   a_carry_write: assert property (apply && w_ctl && wstrb_r[0] && !u_hi_load
      |=> ctl_r[B_CARRY] == $past(wdata_r[0])) else $error("carry write lost");
   a_carry_keep: assert property (!(apply && w_ctl) && !u_hi_load
      |=> $stable(ctl_r[B_CARRY])) else $error("carry changed without cause");
endmodule

// ---- hmc_pkg.sv ----
// shared constants of the multiplier control block
package hmc_pkg;
   localparam int AW = 8;
   localparam int DW = 32;

   // register indices; the bus byte address is four times the index
   localparam logic [7:0] IDX_UPROD    = 8'h00;
   localparam logic [7:0] IDX_SPROD    = 8'h02;
   localparam logic [7:0] IDX_UACC     = 8'h04;
   localparam logic [7:0] IDX_SACC     = 8'h06;
   localparam logic [7:0] IDX_OP2      = 8'h08;
   localparam logic [7:0] IDX_SPLO     = 8'h0A;
   localparam logic [7:0] IDX_SPHI     = 8'h0C;
   localparam logic [7:0] IDX_UPROD_L  = 8'h10;
   localparam logic [7:0] IDX_UPROD_H  = 8'h12;
   localparam logic [7:0] IDX_SPROD_L  = 8'h14;
   localparam logic [7:0] IDX_SPROD_H  = 8'h16;
   localparam logic [7:0] IDX_UACC_L   = 8'h18;
   localparam logic [7:0] IDX_UACC_H   = 8'h1A;
   localparam logic [7:0] IDX_SACC_L   = 8'h1C;
   localparam logic [7:0] IDX_SACC_H   = 8'h1E;
   localparam logic [7:0] IDX_OP2L     = 8'h20;
   localparam logic [7:0] IDX_OP2H     = 8'h22;
   localparam logic [7:0] IDX_RW0      = 8'h24;
   localparam logic [7:0] IDX_RW1      = 8'h26;
   localparam logic [7:0] IDX_RW2      = 8'h28;
   localparam logic [7:0] IDX_RW3      = 8'h2A;
   localparam logic [7:0] IDX_CTL0     = 8'h2C;

   localparam logic [7:0] ADR_UPROD    = IDX_UPROD << 2;
   localparam logic [7:0] ADR_SPROD    = IDX_SPROD << 2;
   localparam logic [7:0] ADR_UACC     = IDX_UACC << 2;
   localparam logic [7:0] ADR_SACC     = IDX_SACC << 2;
   localparam logic [7:0] ADR_OP2      = IDX_OP2 << 2;
   localparam logic [7:0] ADR_SPLO     = IDX_SPLO << 2;
   localparam logic [7:0] ADR_SPHI     = IDX_SPHI << 2;
   localparam logic [7:0] ADR_UPROD_L  = IDX_UPROD_L << 2;
   localparam logic [7:0] ADR_UPROD_H  = IDX_UPROD_H << 2;
   localparam logic [7:0] ADR_SPROD_L  = IDX_SPROD_L << 2;
   localparam logic [7:0] ADR_SPROD_H  = IDX_SPROD_H << 2;
   localparam logic [7:0] ADR_UACC_L   = IDX_UACC_L << 2;
   localparam logic [7:0] ADR_UACC_H   = IDX_UACC_H << 2;
   localparam logic [7:0] ADR_SACC_L   = IDX_SACC_L << 2;
   localparam logic [7:0] ADR_SACC_H   = IDX_SACC_H << 2;
   localparam logic [7:0] ADR_OP2L     = IDX_OP2L << 2;
   localparam logic [7:0] ADR_OP2H     = IDX_OP2H << 2;
   localparam logic [7:0] ADR_RW0      = IDX_RW0 << 2;
   localparam logic [7:0] ADR_RW1      = IDX_RW1 << 2;
   localparam logic [7:0] ADR_RW2      = IDX_RW2 << 2;
   localparam logic [7:0] ADR_RW3      = IDX_RW3 << 2;
   localparam logic [7:0] ADR_CTL0     = IDX_CTL0 << 2;

   // control word fields
   localparam int B_CARRY = 0;
   localparam int B_FRAC  = 2;
   localparam int B_SAT   = 3;
   localparam int B_OPLO  = 4;
   localparam int B_OPHI  = 5;
   localparam int B_OP1W  = 6;
   localparam int B_OP2W  = 7;
   localparam int B_HWEN  = 8;
   localparam int B_DLY32 = 9;
   localparam logic [15:0] CTL_RST   = 16'h0000;
   localparam logic [15:0] CTL_WMASK = 16'h03FD;

   // result staging: low words ready first, then the high words
   localparam logic [2:0] LO_CYC = 3'h2;
   localparam logic [2:0] HI_CYC = 3'h4;

   localparam logic [63:0] SAT_POS_W = 64'h7FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] SAT_NEG_W = 64'h8000_0000_0000_0000;
   localparam logic [63:0] SAT_POS_S = 64'h0000_0000_7FFF_FFFF;
   localparam logic [63:0] SAT_NEG_S = 64'hFFFF_FFFF_8000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      OP_UMUL = 2'h0,
      OP_SMUL = 2'h1,
      OP_UACC = 2'h2,
      OP_SACC = 2'h3
   } hmc_op_t;

   typedef enum logic [2:0] {
      WS_IDLE = 3'h1,
      WS_WAIT = 3'h2,
      WS_RESP = 3'h4
   } hmc_wst_t;
endpackage

// ---- hmc_mul_unit.sv ----
`timescale 1ns/10ps
// product engine with staged readiness of low and high result words
module hmc_mul_unit (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            start,
   input  wire logic [31:0]     op1,
   input  wire logic [31:0]     op2,
   input  wire logic            op1_wide,
   input  wire logic            op2_wide,
   input  wire hmc_pkg::hmc_op_t op,
   input  wire logic            sat,
   input  wire logic            frac,
   input  wire logic [63:0]     acc_in,
   input  wire logic            carry_in,
   output logic      [63:0]     res,
   output logic                 carry,
   output logic                 lo_load,
   output logic                 hi_load,
   output logic                 lo_ready,
   output logic                 hi_ready
);
   import hmc_pkg::*;

   logic [2:0]  cnt_r;
   logic [2:0]  cnt_nxt;
   logic [63:0] res_r;
   logic [63:0] res_nxt;
   logic        carry_r;
   logic        carry_nxt;

   wire               sg   = op[0];
   wire               accu = op[1];
   wire               wide = op1_wide | op2_wide;
   wire [31:0]        a    = op1_wide ? op1 : {{16{sg & op1[15]}}, op1[15:0]};
   wire [31:0]        b    = op2_wide ? op2 : {{16{sg & op2[15]}}, op2[15:0]};
   wire signed [65:0] prod_full = $signed({sg & a[31], a}) * $signed({sg & b[31], b});
   wire [63:0]        prod = frac ? {prod_full[62:0], 1'b0} : prod_full[63:0];
   // the carry joins the accumulator as its top bit, so a restored carry is used
   wire [64:0]        sum_w = (accu ? {carry_in, acc_in} : 65'h0) + {sg & prod[63], prod};
   wire [32:0]        sum_s = (accu ? {carry_in, acc_in[31:0]} : 33'h0)
                              + {sg & prod[31], prod[31:0]};
   wire               ovf_w = sg & (sum_w[64] ^ sum_w[63]);
   wire               ovf_s = sg & (sum_s[32] ^ sum_s[31]);

   always_comb begin
      res_nxt   = res_r;
      carry_nxt = carry_r;
      cnt_nxt   = cnt_r;
      if (start) begin
         cnt_nxt = 3'h1;
         if (wide) begin
            res_nxt   = sum_w[63:0];
            carry_nxt = sum_w[64];
            if (sat && ovf_w) begin
               res_nxt = sum_w[64] ? SAT_NEG_W : SAT_POS_W;
            end
         end else begin
            res_nxt   = {{32{sg & sum_s[31]}}, sum_s[31:0]};
            carry_nxt = sum_s[32];
            if (sat && ovf_s) begin
               res_nxt = sum_s[32] ? SAT_NEG_S : SAT_POS_S;
            end
         end
      end else if (cnt_r == HI_CYC) begin
         cnt_nxt = 3'h0;
      end else if (cnt_r != 3'h0) begin
         cnt_nxt = cnt_r + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r   <= 3'h0;
         res_r   <= 64'h0;
         carry_r <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         res_r   <= res_nxt;
         carry_r <= carry_nxt;
      end
   end

   assign res      = res_r;
   assign carry    = carry_r;
   assign lo_load  = (cnt_r == LO_CYC);
   assign hi_load  = (cnt_r == HI_CYC);
   assign lo_ready = (cnt_r == 3'h0) || (cnt_r > LO_CYC);
   assign hi_ready = (cnt_r == 3'h0);

   // an undisturbed start gives the low words at +2 and the high words at +4
   sequence s_clean_start;
      start ##1 (!start) [*3];
   endsequence
   a_stage_timing: assert property (@(posedge clk) disable iff (!rst_n)
      s_clean_start |=> hi_load && $past(lo_load, 2))
      else $error("result stages out of step");
endmodule

// ---- hmc_master.sv ----
`timescale 1ns/10ps
// processor-side register bus master model
module hmc_master (
   input  wire logic        clk,
   output logic      [7:0]  awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic      [31:0] wdata,
   output logic      [3:0]  wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic        bvalid,
   output logic             bready,
   output logic      [7:0]  araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic        rvalid,
   output logic             rready
);
   logic tmo = 1'b0;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // called just after an edge; no idle edge, so writes go back to back
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      int n;
      awaddr  <= a;
      wdata   <= {16'h0000, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      tmo |= (n == 99);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      tmo |= (n == 99);
   endtask
endmodule

// ---- tb_hmc_top.sv ----
`timescale 1ns/10ps
// self-checking bench for the multiplier control block
module tb_hmc_top;
   import hmc_pkg::*;
   logic        MCLK = 1'b0;
   logic        RST_N;
   logic [7:0]  AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP;
   logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic        ARVALID, ARREADY, RVALID, RREADY;
   int          bad_count = 0;
   int          num_checks = 0;
   int          seed = 59;
   int          i;
   logic [15:0] a, b;
   logic [31:0] p;
   logic [33:0] rq[$], mq[$];
   logic [1:0]  bq[$];
   logic [7:0]  nm[4] = '{ADR_UPROD, ADR_UPROD_L, ADR_SPROD, ADR_SPROD_L};
   logic [15:0] hc[3] = '{16'h0100, 16'h0300, 16'h0000};
   logic [15:0] hx[3] = '{16'hABCD, 16'h0000, 16'h0000};
   always #2.5 MCLK = ~MCLK;
   hmc_top uut (.MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
   hmc_master pm (.clk(MCLK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
      .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bvalid(BVALID),
      .bready(BREADY), .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
      .rvalid(RVALID), .rready(RREADY));
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (pm.tmo) bad_count++;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic w(input logic [7:0] ad, input logic [15:0] d, input logic [3:0] s = 4'h3,
                    input logic [1:0] e = RESP_OKAY);
      bq.push_back(e);
      pm.wr(ad, d, s);
      if (pm.tmo) results();
   endtask
   task automatic r(input logic [7:0] ad, input logic [15:0] e, input logic [15:0] m = 16'hFFFF,
                    input logic [1:0] rs = RESP_OKAY);
      rq.push_back({rs, 16'h0000, e & m});
      mq.push_back({18'h3FFFF, m});
      pm.rd(ad);
      if (pm.tmo) results();
   endtask
   // an empty queue yields an impossible response code, so strays show up
   always @(posedge MCLK) begin
      if (RVALID && RREADY)
         check({RRESP, RDATA} & (mq.size() ? mq.pop_front() : '1),
               rq.size() ? rq.pop_front() : '1);
      if (BVALID && BREADY)
         check({32'h0, BRESP}, {32'h0, bq.size() ? bq.pop_front() : 2'h1});
   end
   initial begin
      // a real falling edge, so the asynchronous clear acts before the first clock
      RST_N <= 1'b0;
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      @(posedge MCLK);
      r(ADR_CTL0, 16'h0000);
      w(ADR_CTL0, 16'h0001);
      w(ADR_UACC, 16'h0001);
      w(ADR_OP2, 16'h0001);
      repeat (8) @(posedge MCLK);
      r(ADR_CTL0, 16'h0021);
      r(ADR_RW0, 16'h0001);
      w(ADR_CTL0, 16'hFCFE);
      r(ADR_CTL0, 16'h00FC);
      w(ADR_CTL0, 16'hFFFF, 4'h2);
      r(ADR_CTL0, 16'h03FC);
      w(ADR_CTL0, 16'h0000);
      for (i = 0; i < 4; i++) begin
         a = $random(seed);
         b = $random(seed);
         if (i < 2) p = a * b;
         else p = $signed(a) * $signed(b);
         w(nm[i], a);
         w(ADR_OP2, b);
         repeat (6) @(posedge MCLK);
         r(ADR_SPLO, p[15:0]);
         r(ADR_RW0, p[15:0]);
         r(ADR_SPHI, p[31:16]);
         r(ADR_RW1, p[31:16]);
         r(ADR_CTL0, {11'h0, i[1], 4'h0}, 16'h0030);
      end
      w(ADR_SPROD_L, 16'h0080, 4'h1);
      w(ADR_OP2, 16'h0002);
      repeat (6) @(posedge MCLK);
      r(ADR_RW0, 16'hFF00);
      r(ADR_RW1, 16'hFFFF);
      // signed accumulate onto the largest positive sum must clamp
      w(ADR_CTL0, 16'h0008);
      w(ADR_RW0, 16'hFFFF);
      w(ADR_RW1, 16'h7FFF);
      w(ADR_SACC, 16'h0001);
      w(ADR_OP2, 16'h0001);
      repeat (6) @(posedge MCLK);
      r(ADR_RW1, 16'h7FFF);
      r(ADR_RW0, 16'hFFFF);
      r(ADR_CTL0, 16'h0038);
      // fractional results come out doubled
      w(ADR_CTL0, 16'h0004);
      w(ADR_UPROD, 16'h0003);
      w(ADR_OP2, 16'h0005);
      repeat (6) @(posedge MCLK);
      r(ADR_RW0, 16'h001E);
      // result-word write lands one edge before the high words load unless held
      for (i = 0; i < 3; i++) begin
         w(ADR_CTL0, hc[i]);
         w(ADR_UPROD, 16'h0003);
         w(ADR_OP2, 16'h0005);
         w(ADR_RW2, 16'hABCD);
         repeat (8) @(posedge MCLK);
         r(ADR_RW2, hx[i]);
      end
      w(8'hFC, 16'h1111, 4'h3, RESP_SLVERR);
      r(8'hFC, 16'h0000, 16'hFFFF, RESP_SLVERR);
      repeat (2) @(posedge MCLK);
      results();
   end
endmodule
